// ---- gpc_config_regs.sv ----
/*
 * Green power transmit and security configuration registers, the learn
 * button event logic and the selected security key output.
 * Assumes a configurator drives the register request port on i_clock and
 * that the learn button and harvester lines are asynchronous pins.
 */
`timescale 1ns/100ps
`include "gpc_cfg.svh"

module gpc_config_regs
    import gpc_pkg::*;
(
    // Clock and reset.
    input  wire logic              i_clock,
    input  wire logic              i_resetn,
    // Configuration port.
    input  wire gpc_reg_req_type   i_reg_req,
    output logic      [7:0]        o_reg_rdata,
    output logic                   o_reg_rvalid,
    // Pins.
    input  wire logic              i_learn_button,
    input  wire logic              i_harvester_action,
    // Radio and security state.
    output logic      [4:0]        o_radio_channel,
    output logic                   o_commission_start,
    output gpc_sec_state_type      o_sec_state,
    output logic      [127:0]      o_auth_key
);

    // ------------------------------------------------------------------------
    // Register file storage
    // ------------------------------------------------------------------------
    // Keys are plain flip-flops, sixteen bytes each, so the byte index is
    // simply the low nibble of the register index.
    logic [7:0] tx_config;
    logic [7:0] sec_config;
    logic [7:0] first_secret_key  [`GPC_KEY_BYTES];
    logic [7:0] second_secret_key [`GPC_KEY_BYTES];

    // ------------------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------------------
    wire        hit_tx;
    wire        hit_sec;
    wire        hit_key1;
    wire        hit_key2;
    wire [3:0]  key_index;
    wire        write_tx;
    wire        write_sec;
    wire        write_key1;
    wire        write_key2;

    // Both key pages are found on the upper nibble of the index alone.
    function automatic logic key_page_hit(
        input logic [7:0] addr,
        input logic [3:0] page
    );
        key_page_hit = (addr[7:4] == page);
    endfunction

    // Exact matches for the two configuration registers.
    assign hit_tx    = (i_reg_req.addr == `GPC_ADDR_TX_CONFIG);
    assign hit_sec   = (i_reg_req.addr == `GPC_ADDR_SEC_CONFIG);
    assign hit_key1  = key_page_hit(i_reg_req.addr, `GPC_KEY1_PAGE);
    assign hit_key2  = key_page_hit(i_reg_req.addr, `GPC_KEY2_PAGE);
    assign key_index = i_reg_req.addr[3:0];

    // Write strobes are qualified by the decoded hit.
    assign write_tx   = i_reg_req.write && hit_tx;
    assign write_sec  = i_reg_req.write && hit_sec;
    assign write_key1 = i_reg_req.write && hit_key1;
    assign write_key2 = i_reg_req.write && hit_key2;

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------

    // All eight bits are stored; the configurator keeps the upper ones at
    // zero, so no masking is spent on them.
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            tx_config <= `GPC_TX_RESET; // R04
        else if (write_tx)
            tx_config <= i_reg_req.wdata; // R05
    end

    // The security register keeps reserved bits as written too, so its
    // reset value reads back unchanged.
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            sec_config <= `GPC_SEC_RESET; // R11
        else if (write_sec)
            sec_config <= i_reg_req.wdata;
    end

    // Key bytes have no reset: secrets are provisioned, not defaulted.
    always_ff @(posedge i_clock)
    begin
        if (write_key1)
            first_secret_key[key_index] <= i_reg_req.wdata;
        if (write_key2)
            second_secret_key[key_index] <= i_reg_req.wdata; // R12
    end

    // ------------------------------------------------------------------------
    // Field extraction and reserved-code handling
    // ------------------------------------------------------------------------
    wire [3:0]               channel_code_field;
    wire [1:0]               policy_field;
    wire [1:0]               wrap_field;
    wire [1:0]               auth_field;
    wire                     pairing_disable;
    gpc_step_policy_type     step_policy;
    gpc_wrap_mode_type       key_wrap_mode;
    wire                     auth_second;

    assign channel_code_field =
        tx_config[`GPC_TX_CODE_MSB:`GPC_TX_CODE_LSB];
    assign policy_field = tx_config[`GPC_TX_POLICY_MSB:`GPC_TX_POLICY_LSB];
    assign wrap_field   = sec_config[`GPC_SEC_WRAP_MSB:`GPC_SEC_WRAP_LSB];
    assign auth_field   = sec_config[`GPC_SEC_AUTH_MSB:`GPC_SEC_AUTH_LSB];
    assign pairing_disable = sec_config[`GPC_SEC_PAIR_BIT];     // R09

    // Reserved encodings fall back to the field default.
    assign step_policy   = gpc_policy_eff(policy_field);         // R13
    assign key_wrap_mode = (wrap_field == GPC_WRAP_RSVD) ?
        GPC_WRAP_DEFAULT_KEY : gpc_wrap_mode_type'(wrap_field); // R13 R06 R07
    assign auth_second   = (auth_field == 2'h1);                 // R08 R13

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic learn_meta;
    logic learn_sync;
    logic harvest_meta;
    logic harvest_sync;
    logic harvest_prev;

    // Learn button: two flops, only its level is used.
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            learn_meta <= 1'b0;
            learn_sync <= 1'b0;
        end
        else
        begin
            learn_meta <= i_learn_button;
            learn_sync <= learn_meta;
        end
    end

    // Harvester: a third flop keeps the last synced level so its rising
    // edge can be found; it reads only the second flop, never the first.
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            harvest_meta <= 1'b0;
            harvest_sync <= 1'b0;
            harvest_prev <= 1'b0;
        end
        else
        begin
            harvest_meta <= i_harvester_action;
            harvest_sync <= harvest_meta;
            harvest_prev <= harvest_sync;
        end
    end

    // ------------------------------------------------------------------------
    // Learn event
    // ------------------------------------------------------------------------
    wire learn_event;
    wire pairing_event;
    wire step_request;

    // The event comes two cycles after the harvester edge; a press is
    // far longer than that, so the delay costs nothing.
    // A learn press counts once per harvester actuation, on its rising edge.
    assign learn_event   = learn_sync && harvest_sync && !harvest_prev;
    assign pairing_event = learn_event && !pairing_disable;      // R09
    // With pairing disabled the channel stays at the programmed code.
    assign step_request  = pairing_event;                        // R10

    // ------------------------------------------------------------------------
    // Channel stepper
    // ------------------------------------------------------------------------
    logic [3:0] active_code;

    // Any write of the transmit register restarts stepping from the code.
    gpc_channel_stepper u_stepper (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_load   (write_tx),
        .i_code   (i_reg_req.wdata[`GPC_TX_CODE_MSB:`GPC_TX_CODE_LSB]),
        .i_step   (step_request),
        .i_policy (step_policy),
        .o_code   (active_code)
    );

    // ------------------------------------------------------------------------
    // Radio channel and commissioning pulse
    // ------------------------------------------------------------------------
    logic       pairing_stage;
    wire  [4:0] next_radio_channel;

    // The band starts at channel 11, so the code is an offset from it.
    assign next_radio_channel =
        5'(`GPC_CHANNEL_BASE + {1'b0, active_code});            // R01

    // The pulse is delayed two cycles so that the channel output already
    // shows the stepped channel when the telegram is started.
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_radio_channel    <= `GPC_CHANNEL_BASE;             // R02
            pairing_stage      <= 1'b0;
            o_commission_start <= 1'b0;
        end
        else
        begin
            o_radio_channel    <= next_radio_channel;
            pairing_stage      <= pairing_event;
            o_commission_start <= pairing_stage;                 // R09
        end
    end

    // ------------------------------------------------------------------------
    // Security state and selected key
    // ------------------------------------------------------------------------
    logic [127:0] selected_key;

    // Byte 0 of each key sits in the top byte of the 128-bit word.
    always_comb
    begin
        selected_key = '0;
        for (int i = 0; i < `GPC_KEY_BYTES; i++)
        begin
            selected_key[127 - 8 * i -: 8] = auth_second ?
                second_secret_key[i] : first_secret_key[i];      // R08
        end
    end

    // Registered so every security output changes on the same edge; the
    // price is one cycle after the register write.
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_sec_state.key_wrap_mode   <= GPC_WRAP_DEFAULT_KEY; // R07
            o_sec_state.auth_second_key <= 1'b0;
            o_sec_state.pairing_enabled <= 1'b1;
            o_auth_key                  <= '0;
        end
        else
        begin
            o_sec_state.key_wrap_mode   <= key_wrap_mode;        // R06
            o_sec_state.auth_second_key <= auth_second;
            o_sec_state.pairing_enabled <= !pairing_disable;
            o_auth_key                  <= selected_key;
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    logic [7:0] read_value;

    // The second key page reads as zero so the secret never leaves.
    always_comb
    begin
        if (hit_tx)
            read_value = tx_config;
        else if (hit_sec)
            read_value = sec_config;
        else if (hit_key1)
            read_value = first_secret_key[key_index];            // R12
        else
            read_value = 8'h00;                                  // R12
    end

    // Read data holds until the next read, so a slow master may take it
    // late; the valid pulse alone marks the answer.
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rvalid <= i_reg_req.read;
            if (i_reg_req.read)
                o_reg_rdata <= read_value;
        end
    end

endmodule

// ---- gpc_cfg.svh ----
/*
 * Constants of the green power transmit and security configuration block:
 * register indices, field positions, reset values and channel figures.
 * Assumes it is included by bare name from the package and the modules.
 */
// How it works
// R01: Channel code 0..15 maps to channels 11..26.
// R02: Factory default channel code zero, channel 11.
// R03: Step policy: fixed, primary channels, all, reserved.
// R04: Transmit register resets to 0x20.
// R05: Configurator writes zero to reserved bits.
// R06: Key wrap mode picks commissioning transport key.
// R07: Standard default link key used by default.
// R08: Auth key choice: first or second secret key.
// R09: Bit 4 set blocks learn-press commissioning telegram.
// R10: Pairing disabled: channel comes only from code.
// R11: Security register resets to 0x20.
// R12: Second secret key write-only, first key readable.
// R13: Reserved codes behave like the field default.
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices on the configuration port
// ----------------------------------------------------------------------------
`define GPC_ADDR_TX_CONFIG   8'h00
`define GPC_ADDR_SEC_CONFIG  8'h01
`define GPC_KEY1_PAGE        4'h1
`define GPC_KEY2_PAGE        4'h2

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define GPC_TX_CODE_MSB      3
`define GPC_TX_CODE_LSB      0
`define GPC_TX_POLICY_MSB    5
`define GPC_TX_POLICY_LSB    4
`define GPC_SEC_WRAP_MSB     1
`define GPC_SEC_WRAP_LSB     0
`define GPC_SEC_AUTH_MSB     3
`define GPC_SEC_AUTH_LSB     2
`define GPC_SEC_PAIR_BIT     4

// ----------------------------------------------------------------------------
// Reset values and channel figures
// ----------------------------------------------------------------------------
`define GPC_TX_RESET         8'h20
`define GPC_SEC_RESET        8'h20
`define GPC_CODE_RESET       4'h0
`define GPC_CHANNEL_BASE     5'h0B
`define GPC_PRIMARY_A        4'h0
`define GPC_PRIMARY_B        4'h4
`define GPC_PRIMARY_C        4'h9
`define GPC_PRIMARY_D        4'hE
`define GPC_KEY_BYTES        16

`endif

// ---- gpc_pkg.sv ----
/*
 * Types shared by the configuration block and its channel stepper.
 * Assumes gpc_cfg.svh is on the include path.
 */
`include "gpc_cfg.svh"

package gpc_pkg;

    // ------------------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        GPC_STEP_FIXED   = 2'h0,
        GPC_STEP_PRIMARY = 2'h1,
        GPC_STEP_ALL     = 2'h2,
        GPC_STEP_RSVD    = 2'h3
    } gpc_step_policy_type;

    typedef enum logic [1:0] {
        GPC_WRAP_DEFAULT_KEY = 2'h0,
        GPC_WRAP_KEY_CODE    = 2'h1,
        GPC_WRAP_SETUP_CODE  = 2'h2,
        GPC_WRAP_RSVD        = 2'h3
    } gpc_wrap_mode_type;

    // ------------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gpc_reg_req_type;

    typedef struct packed {
        gpc_wrap_mode_type key_wrap_mode;
        logic              auth_second_key;
        logic              pairing_enabled;
    } gpc_sec_state_type;

    // Reserved step policy acts as the default policy.
    function automatic gpc_step_policy_type gpc_policy_eff(
        input logic [1:0] raw
    );
        gpc_policy_eff = (raw == GPC_STEP_RSVD) ? GPC_STEP_ALL
                                                : gpc_step_policy_type'(raw);
    endfunction

endpackage

// ---- gpc_channel_stepper.sv ----
/*
 * Channel stepper: holds the channel code in use and advances it on a
 * learn event according to the step policy.
 * Assumes load and step come from logic on the same clock.
 */
`timescale 1ns/100ps
`include "gpc_cfg.svh"

module gpc_channel_stepper
    import gpc_pkg::*;
(
    // Clock and reset.
    input  wire logic                i_clock,
    input  wire logic                i_resetn,
    // Control.
    input  wire logic                i_load,
    input  wire logic [3:0]          i_code,
    input  wire logic                i_step,
    input  wire gpc_step_policy_type i_policy,
    // Result.
    output logic      [3:0]          o_code
);

    // ------------------------------------------------------------------------
    // Next-code arithmetic
    // ------------------------------------------------------------------------

    // Next primary channel above the current code, wrapping to the first.
    function automatic logic [3:0] next_primary(input logic [3:0] code);
        if (code < `GPC_PRIMARY_B)
            next_primary = `GPC_PRIMARY_B;
        else if (code < `GPC_PRIMARY_C)
            next_primary = `GPC_PRIMARY_C;
        else if (code < `GPC_PRIMARY_D)
            next_primary = `GPC_PRIMARY_D;
        else
            next_primary = `GPC_PRIMARY_A;
    endfunction

    logic [3:0] step_all_code;
    logic [3:0] next_code;

    // The four-bit sum wraps channel 26 back to channel 11.
    assign step_all_code = 4'(o_code + 4'h1);
    assign next_code = i_load ? i_code :                          // R03
        (i_step && i_policy == GPC_STEP_PRIMARY) ? next_primary(o_code) :
        (i_step && i_policy == GPC_STEP_ALL) ? step_all_code :
        o_code;

    // ------------------------------------------------------------------------
    // Code register
    // ------------------------------------------------------------------------

    // A write of the code wins over a step in the same cycle.
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
            o_code <= `GPC_CODE_RESET; // R02
        else
            o_code <= next_code;
    end

endmodule

// ---- gpc_regs_props.sv ----
/* Concurrent checks on the configuration register block's ports.
   Assumes the gpc package and header; bound to the block's top. */
`timescale 1ns/100ps
`include "gpc_cfg.svh"

module gpc_regs_props
    import gpc_pkg::*;
(
    // Clock and reset.
    input wire logic              i_clock,
    input wire logic              i_resetn,
    // Configuration port.
    input wire gpc_reg_req_type   i_reg_req,
    input wire logic [7:0]        o_reg_rdata,
    input wire logic              o_reg_rvalid,
    // Pins and state.
    input wire logic              i_learn_button,
    input wire logic              i_harvester_action,
    input wire logic [4:0]        o_radio_channel,
    input wire logic              o_commission_start,
    input wire gpc_sec_state_type o_sec_state,
    input wire logic [127:0]      o_auth_key
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    // Writes to the two configuration registers.
    wire wr_tx  = i_reg_req.write && i_reg_req.addr == `GPC_ADDR_TX_CONFIG;
    wire wr_sec = i_reg_req.write && i_reg_req.addr == `GPC_ADDR_SEC_CONFIG;

    // A learn press as seen on the pins, before synchronising.
    sequence press_s;
        i_learn_button && $rose(i_harvester_action);
    endsequence

    chan_in_band_a: assert property (
        o_radio_channel >= 5'h0B && o_radio_channel <= 5'h1A)
        else $error("channel out of band");
    tx_code_map_a: assert property (
        wr_tx |-> ##2 o_radio_channel ==
            5'h0B + {1'b0, $past(i_reg_req.wdata[3:0], 2)})
        else $error("channel does not follow code");
    reset_state_a: assert property (
        $rose(i_resetn) |->
            o_radio_channel == 5'h0B && o_sec_state == 4'h1)
        else $error("bad state after reset");
    pair_bit_a: assert property (
        wr_sec |-> ##2 o_sec_state.pairing_enabled ==
            !$past(i_reg_req.wdata[4], 2))
        else $error("pairing enable wrong");
    auth_pick_a: assert property (
        wr_sec |-> ##2 o_sec_state.auth_second_key ==
            ($past(i_reg_req.wdata[3:2], 2) == 2'h1))
        else $error("auth key choice wrong");
    wrap_pick_a: assert property (
        wr_sec |-> ##2 o_sec_state.key_wrap_mode ==
            (($past(i_reg_req.wdata[1:0], 2) == 2'h3) ? 2'h0
                : $past(i_reg_req.wdata[1:0], 2)))
        else $error("wrap mode wrong");
    sec_hold_a: assert property (
        !$past(wr_sec, 2) |-> $stable(o_sec_state))
        else $error("security state moved");
    key2_hidden_a: assert property (
        i_reg_req.read && i_reg_req.addr[7:4] == 4'h2 |=>
            o_reg_rdata == 8'h00)
        else $error("second key readable");
    rd_answer_a: assert property (i_reg_req.read |=> o_reg_rvalid)
        else $error("read not answered");
    pair_go_a: assert property (
        press_s ##0 o_sec_state.pairing_enabled |->
            ##[2:7] o_commission_start)
        else $error("no commissioning pulse");
    pair_off_a: assert property (
        press_s ##0 !o_sec_state.pairing_enabled |->
            ##1 !o_commission_start [*8])
        else $error("pulse while disabled");
    pulse_once_a: assert property (
        o_commission_start |=> !o_commission_start)
        else $error("pulse too long");
endmodule

bind gpc_config_regs gpc_regs_props u_props (.*);

// ---- gpc_button_model.sv ----
/* Pushbutton model standing for the user: a press request holds the learn
   button and actuates the harvester once inside that hold.
   Assumes i_press is a one-cycle pulse on i_clock. */
`timescale 1ns/100ps

module gpc_button_model
(
    // Clock and request.
    input  wire logic i_clock,
    input  wire logic i_press,
    // Pins toward the block.
    output logic      o_learn_button,
    output logic      o_harvester_action
);
    logic [3:0] phase = 4'h0;

    // Learn is held around the whole harvester pulse so both sync high.
    always @(posedge i_clock)
    begin
        if (i_press)
            phase <= 4'h1;
        else if (phase != 4'h0)
            phase <= (phase == 4'hC) ? 4'h0 : phase + 4'h1;
    end

    // A released button is simply low; the harvester rises only once.
    assign o_learn_button     = (phase != 4'h0);
    assign o_harvester_action = (phase >= 4'h3) && (phase <= 4'h8);
endmodule

// ---- gpc_config_regs_tb_top.sv ----
/* Self-checking bench for the configuration register block.
   Assumes the gpc package, the checker and the button model. */
`timescale 1ns/100ps
`include "gpc_cfg.svh"

module gpc_config_regs_tb_top
    import gpc_pkg::*;
;
    logic              i_clock = 1'b0;
    logic              i_resetn = 1'b0;
    gpc_reg_req_type   req = '0;
    logic              press = 1'b0;
    logic              learn, harv, rvalid, start;
    logic [7:0]        rdata;
    logic [4:0]        chan;
    gpc_sec_state_type sec;
    logic [127:0]      akey;
    logic [127:0]      key1 = '0;
    logic [127:0]      key2 = '0;
    int                fails = 0;
    int                checked = 0;
    int                cycles = 0;

    gpc_config_regs dut (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_reg_req(req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_learn_button(learn), .i_harvester_action(harv),
        .o_radio_channel(chan), .o_commission_start(start),
        .o_sec_state(sec), .o_auth_key(akey));
    gpc_button_model model (.i_clock(i_clock), .i_press(press),
        .o_learn_button(learn), .o_harvester_action(harv));

    // Clock, and a ceiling well above the few hundred cycles needed.
    initial forever #5 i_clock = ~i_clock;
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            fails++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write, then wait until derived outputs have settled.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge i_clock);
        req.write <= 1'b0;
        repeat (2) @(posedge i_clock);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_clock);
        req.read <= 1'b0;
        #1;
        check(rvalid, 1'b1);
        d = rdata;
    endtask

    // One learn press through the model; reports whether a pulse came.
    task automatic pr(output logic seen);
        seen = 1'b0;
        @(posedge i_clock);
        press <= 1'b1;
        @(posedge i_clock);
        press <= 1'b0;
        repeat (16)
        begin
            @(posedge i_clock);
            #1;
            if (start === 1'b1) seen = 1'b1;
        end
    endtask

    task automatic t_reset();
        logic [7:0] d;
        rd(8'h00, d);
        check(d, 8'h20);
        rd(8'h01, d);
        check(d, 8'h20);
        check(chan, 5'h0B);
        check(sec, 4'h1);
        rd(8'h40, d);
        check(d, 8'h00);
    endtask

    // Every channel code; upper bits are written as zero.
    task automatic t_map();
        logic [7:0] d;
        for (int i = 0; i < 16; i++)
        begin
            wr(8'h00, 8'(i));
            check(chan, 5'h0B + 5'(i));
            rd(8'h00, d);
            check(d, 8'(i));
        end
    endtask

    // Keys, then every wrap mode and key choice code.
    task automatic t_keys();
        logic [7:0] d;
        for (int i = 0; i < 16; i++)
        begin
            wr(8'h10 + 8'(i), 8'hA0 + 8'(i));
            wr(8'h20 + 8'(i), 8'h50 + 8'(i));
            key1 = {key1[119:0], 8'hA0 + 8'(i)};
            key2 = {key2[119:0], 8'h50 + 8'(i)};
        end
        rd(8'h13, d);
        check(d, 8'hA3);
        rd(8'h23, d);
        check(d, 8'h00);
        for (int v = 0; v < 16; v++)
        begin
            wr(8'h01, 8'(v));
            check(sec.key_wrap_mode, (v % 4 == 3) ? 2'h0 : 2'(v));
            check(sec.auth_second_key, v / 4 == 1);
            check(akey, (v / 4 == 1) ? key2 : key1);
        end
    endtask

    // Step policy cases as {policy, start code, next code}.
    task automatic t_step();
        logic [11:0] cases [5] = '{12'h2F0, 12'h149, 12'h1E0, 12'h077,
                                   12'h356};
        logic        seen;
        wr(8'h01, 8'h00);
        foreach (cases[k])
        begin
            wr(8'h00, {2'b00, cases[k][9:4]});
            pr(seen);
            check(seen, 1'b1);
            check(chan, 5'h0B + {1'b0, cases[k][3:0]});
        end
        wr(8'h01, 8'h10);
        wr(8'h00, 8'h23);
        pr(seen);
        check(seen, 1'b0);
        check(chan, 5'h0E);
    endtask

    // Reset for six cycles, then the scenarios in turn.
    initial
    begin
        repeat (6) @(posedge i_clock);
        i_resetn <= 1'b1;
        t_reset();
        t_map();
        t_keys();
        t_step();
        wrap_up();
    end
endmodule
